// [rtl/srm_reg_bank.sv]
// What this block does
// - every register is eight bits, bit 7 msb
// - map: port config, index/transfer, program registers
// - program registers shadowed; four registers act directly
// - any reset loads defaults into registers
// - clock register resets to 0x01
// - mirrored lsb-first bits 6/1; reset 0x18
// - bits 5/2 request soft reset, self-clearing
// - 0x01 read-only part identifier
// - 0x02 speed grade in bits 5:4
// - upper index bits 3:0 select channels H..E
// - lower index bits 3:0 select channels D..A
// - lower index bits 5/4 select clock channels
// - 16-bit instruction then data bytes
// - 0xFF bit 0 is the commit bit
`timescale 1ns/1ps
`default_nettype none

module srm_reg_bank
  import srm_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5a, // part_identifier value is arbitrary
  parameter logic [1:0] SPEED_GRADE = 2'h0,
  parameter int CH_COUNT = srm_pkg::NUM_CH
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  // serial port pins
  input wire logic sclk,
  input wire logic csb,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  // active register contents
  output logic lsb_first,
  output logic [7:0] modes_active,
  output logic [7:0] clock_active,
  output logic [CH_COUNT*8-1:0] test_io_active,
  output logic [CH_COUNT-1:0] channel_select,
  output logic commit_pending
);

  import srm_pkg::*;

  // index registers only name ten channels
  if (CH_COUNT != NUM_CH) begin : g_bad_ch
    $error("srm_reg_bank: channel count is fixed by the index registers");
  end

  typedef struct packed {
    srm_phase_e phase;
    logic [3:0] bit_cnt;
    logic [SRM_INSTR_W-1:0] shift;
    logic rd;
    logic [1:0] len;
    logic [1:0] byte_cnt;
    logic [SRM_ADDR_W-1:0] addr;
    logic [7:0] rd_byte;
    logic sclk_d;
    logic sdio_out;
    logic sdio_oe_n;
    logic lsb_first;
    logic [CH_UPPER_W-1:0] ch_upper;
    logic [CH_LOWER_W-1:0] ch_lower;
    logic xfer;
    logic [7:0] modes_sh;
    logic [7:0] modes_act;
    logic [7:0] clk_sh;
    logic [7:0] clk_act;
    logic [CH_COUNT-1:0][7:0] tio_sh;
    logic [CH_COUNT-1:0][7:0] tio_act;
  } srm_state_s;

  localparam srm_state_s RST_STATE = '{
    phase: PH_INSTR,
    bit_cnt: 4'h0,
    shift: 16'h0000,
    rd: 1'b0,
    len: 2'h0,
    byte_cnt: 2'h0,
    addr: 13'h0000,
    rd_byte: 8'h00,
    sclk_d: 1'b0,
    sdio_out: 1'b0,
    sdio_oe_n: 1'b1,
    lsb_first: RST_PORT_CFG[CFG_LSB_LO],
    ch_upper: RST_CH_UPPER,
    ch_lower: RST_CH_LOWER,
    xfer: RST_XFER,
    modes_sh: RST_MODES,
    modes_act: RST_MODES,
    clk_sh: RST_CLOCK,
    clk_act: RST_CLOCK,
    tio_sh: {CH_COUNT{RST_TEST_IO}},
    tio_act: {CH_COUNT{RST_TEST_IO}}
  };

  srm_state_s st;
  srm_state_s next_st;
  logic rise;
  logic fall;

  srm_pins_if pins ();

  srm_pin_sync u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .ce(ce),
    .pin_raw({sdio_in, csb, sclk}),
    .pins(pins.sync)
  );

  // data channels A..H in bits 0..7, frame clock 8, data clock 9
  function automatic logic [CH_COUNT-1:0] chan_mask(input srm_state_s s);
    chan_mask = {s.ch_lower[CH_LOWER_W-1:CH_DATA_LOWER], s.ch_upper,
                 s.ch_lower[CH_DATA_LOWER-1:0]};
  endfunction

  // register readback; unmapped addresses read zero
  function automatic logic [7:0] read_reg(input srm_state_s s, input logic [SRM_ADDR_W-1:0] a);
    logic [CH_COUNT-1:0] m;
    m = chan_mask(s);
    read_reg = 8'h00;
    case (a)
      ADDR_PORT_CFG: begin
        read_reg = RST_PORT_CFG;
        read_reg[CFG_LSB_HI] = s.lsb_first;
        read_reg[CFG_LSB_LO] = s.lsb_first;
      end
      ADDR_PART_ID: read_reg = PART_ID;
      ADDR_SPEED: read_reg = RST_SPEED | (8'(SPEED_GRADE) << GRADE_LSB);
      ADDR_CH_UPPER: read_reg = {{(8 - CH_UPPER_W){1'b0}}, s.ch_upper};
      ADDR_CH_LOWER: read_reg = {{(8 - CH_LOWER_W){1'b0}}, s.ch_lower};
      ADDR_XFER: read_reg = {7'h00, s.xfer};
      ADDR_MODES: read_reg = s.modes_sh;
      ADDR_CLOCK: read_reg = s.clk_sh;
      ADDR_TEST_IO: begin
        // lowest selected channel answers; the loop runs downward so the lowest index is assigned last
        for (int c = CH_COUNT - 1; c >= 0; c--) begin
          if (m[c]) begin
            read_reg = s.tio_sh[c];
          end
        end
      end
      default: read_reg = 8'h00;
    endcase
  endfunction

  // soft reset touches the registers only; the frame in progress goes on
  function automatic srm_state_s load_defaults(input srm_state_s s);
    load_defaults = s;
    load_defaults.lsb_first = RST_STATE.lsb_first;
    load_defaults.ch_upper = RST_STATE.ch_upper;
    load_defaults.ch_lower = RST_STATE.ch_lower;
    load_defaults.xfer = RST_STATE.xfer;
    load_defaults.modes_sh = RST_STATE.modes_sh;
    load_defaults.modes_act = RST_STATE.modes_act;
    load_defaults.clk_sh = RST_STATE.clk_sh;
    load_defaults.clk_act = RST_STATE.clk_act;
    load_defaults.tio_sh = RST_STATE.tio_sh;
    load_defaults.tio_act = RST_STATE.tio_act;
  endfunction

  function automatic srm_state_s write_reg(input srm_state_s s, input logic [SRM_ADDR_W-1:0] a,
                                           input logic [7:0] d);
    logic [CH_COUNT-1:0] m;
    m = chan_mask(s);
    write_reg = s;
    case (a)
      ADDR_PORT_CFG: begin
        // either mirror bit is enough, so a byte sent in the wrong order still works
        write_reg.lsb_first = d[CFG_LSB_HI] | d[CFG_LSB_LO];
        if (d[CFG_SRST_HI] | d[CFG_SRST_LO]) begin
          write_reg = load_defaults(write_reg);
        end
      end
      ADDR_CH_UPPER: write_reg.ch_upper = d[CH_UPPER_W-1:0];
      ADDR_CH_LOWER: write_reg.ch_lower = d[CH_LOWER_W-1:0];
      ADDR_XFER: write_reg.xfer = d[XFER_BIT];
      ADDR_MODES: write_reg.modes_sh = d;
      ADDR_CLOCK: write_reg.clk_sh = d;
      ADDR_TEST_IO: begin
        for (int c = 0; c < CH_COUNT; c++) begin
          if (m[c]) begin
            write_reg.tio_sh[c] = d;
          end
        end
      end
      // read-only and unmapped addresses ignore writes
      default: write_reg = s;
    endcase
  endfunction

  assign rise = pins.sclk & ~st.sclk_d;
  assign fall = ~pins.sclk & st.sclk_d;

  always_comb begin
    logic [SRM_INSTR_W-1:0] shifted;
    logic [7:0] data;
    logic [SRM_ADDR_W-1:0] step;
    shifted = 16'h0000;
    data = 8'h00;
    step = 13'h0000;
    next_st = st;
    next_st.sclk_d = pins.sclk;

    // one cycle after the transfer bit is set every shadow moves over
    if (st.xfer) begin
      next_st.modes_act = st.modes_sh;
      next_st.clk_act = st.clk_sh;
      next_st.tio_act = st.tio_sh;
      next_st.xfer = 1'b0;
    end

    if (pins.csb) begin
      next_st.sdio_oe_n = 1'b1;
      // mid-byte or end of streaming drops the frame; a byte boundary only stalls it
      if (st.bit_cnt != 4'h0 || (st.phase == PH_DATA && st.len == LEN_STREAM)) begin
        next_st.phase = PH_INSTR;
        next_st.bit_cnt = 4'h0;
      end
    end else if (rise) begin
      if (st.lsb_first) begin
        shifted = {pins.sdio, st.shift[SRM_INSTR_W-1:1]};
      end else begin
        shifted = {st.shift[SRM_INSTR_W-2:0], pins.sdio};
      end
      next_st.shift = shifted;
      if (st.phase == PH_INSTR) begin
        if (st.bit_cnt == LAST_INSTR_BIT) begin
          next_st.rd = shifted[INSTR_RW_BIT];
          next_st.len = shifted[INSTR_LEN_LSB +: 2];
          next_st.addr = shifted[SRM_ADDR_W-1:0];
          next_st.rd_byte = read_reg(st, shifted[SRM_ADDR_W-1:0]);
          next_st.byte_cnt = 2'h0;
          next_st.bit_cnt = 4'h0;
          next_st.phase = PH_DATA;
        end else begin
          next_st.bit_cnt = st.bit_cnt + 4'h1;
        end
      end else begin
        if (st.bit_cnt == LAST_DATA_BIT) begin
          // a right-shifted byte lands in the upper half
          data = st.lsb_first ? shifted[SRM_INSTR_W-1:SRM_BYTE_W] : shifted[SRM_BYTE_W-1:0];
          // address runs down in msb-first mode and up in lsb-first mode
          step = st.lsb_first ? st.addr + ADDR_STEP : st.addr - ADDR_STEP;
          if (!st.rd) begin
            next_st = write_reg(next_st, st.addr, data);
          end
          next_st.addr = step;
          next_st.rd_byte = read_reg(st, step);
          next_st.bit_cnt = 4'h0;
          next_st.byte_cnt = st.byte_cnt + 2'h1;
          if (st.len != LEN_STREAM && st.byte_cnt == st.len) begin
            next_st.phase = PH_INSTR;
            next_st.sdio_oe_n = 1'b1;
          end
        end else begin
          next_st.bit_cnt = st.bit_cnt + 4'h1;
        end
      end
    end else if (fall && st.phase == PH_DATA && st.rd) begin
      // drive on the falling edge so the bit is settled for the host's rising edge
      next_st.sdio_oe_n = 1'b0;
      if (st.lsb_first) begin
        next_st.sdio_out = st.rd_byte[0];
        next_st.rd_byte = {1'b0, st.rd_byte[7:1]};
      end else begin
        next_st.sdio_out = st.rd_byte[7];
        next_st.rd_byte = {st.rd_byte[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= RST_STATE;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign sdio_out = st.sdio_out;
  assign sdio_oe_n = st.sdio_oe_n;
  assign lsb_first = st.lsb_first;
  assign modes_active = st.modes_act;
  assign clock_active = st.clk_act;
  assign test_io_active = st.tio_act;
  assign channel_select = {st.ch_lower[CH_LOWER_W-1:CH_DATA_LOWER], st.ch_upper, st.ch_lower[CH_DATA_LOWER-1:0]};
  assign commit_pending = st.xfer;

endmodule

`default_nettype wire

// [common/srm_pkg.sv]
package srm_pkg;

  // frame layout
  localparam int SRM_ADDR_W = 13;
  localparam int SRM_BYTE_W = 8;
  localparam int SRM_INSTR_W = 16;
  localparam int INSTR_RW_BIT = 15;
  localparam int INSTR_LEN_LSB = 13;
  localparam logic [3:0] LAST_INSTR_BIT = 4'hf;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [1:0] LEN_STREAM = 2'h3;
  localparam logic [SRM_ADDR_W-1:0] ADDR_STEP = 13'h0001;

  // register addresses
  localparam logic [SRM_ADDR_W-1:0] ADDR_PORT_CFG = 13'h0000;
  localparam logic [SRM_ADDR_W-1:0] ADDR_PART_ID = 13'h0001;
  localparam logic [SRM_ADDR_W-1:0] ADDR_SPEED = 13'h0002;
  localparam logic [SRM_ADDR_W-1:0] ADDR_CH_UPPER = 13'h0004;
  localparam logic [SRM_ADDR_W-1:0] ADDR_CH_LOWER = 13'h0005;
  localparam logic [SRM_ADDR_W-1:0] ADDR_MODES = 13'h0008;
  localparam logic [SRM_ADDR_W-1:0] ADDR_CLOCK = 13'h0009;
  localparam logic [SRM_ADDR_W-1:0] ADDR_TEST_IO = 13'h000d;
  localparam logic [SRM_ADDR_W-1:0] ADDR_XFER = 13'h00ff;

  // reset values
  localparam logic [7:0] RST_PORT_CFG = 8'h18;
  localparam logic [7:0] RST_SPEED = 8'h00;
  localparam logic [3:0] RST_CH_UPPER = 4'hf;
  localparam logic [5:0] RST_CH_LOWER = 6'h0f;
  localparam logic RST_XFER = 1'b0;
  localparam logic [7:0] RST_MODES = 8'h00;
  localparam logic [7:0] RST_CLOCK = 8'h01;
  localparam logic [7:0] RST_TEST_IO = 8'h00;

  // field positions
  localparam int CFG_LSB_HI = 6;
  localparam int CFG_SRST_HI = 5;
  localparam int CFG_SRST_LO = 2;
  localparam int CFG_LSB_LO = 1;
  localparam int XFER_BIT = 0;
  localparam int GRADE_LSB = 4;
  localparam int CH_UPPER_W = 4;
  localparam int CH_LOWER_W = 6;
  localparam int CH_DATA_LOWER = 4;
  localparam int NUM_CH = 10;

  // pin synchroniser
  localparam int NUM_PINS = 3;
  localparam int PIN_SCLK = 0;
  localparam int PIN_CSB = 1;
  localparam int PIN_SDIO = 2;
  localparam logic [NUM_PINS-1:0] PIN_RST = 3'h2;

  typedef enum logic {
    PH_INSTR = 1'b0,
    PH_DATA = 1'b1
  } srm_phase_e;

endpackage

// [common/srm_pins_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface srm_pins_if;
  logic sclk;
  logic csb;
  logic sdio;

  modport sync (output sclk, output csb, output sdio);
  modport core (input sclk, input csb, input sdio);
endinterface

`default_nettype wire

// [rtl/srm_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module srm_pin_sync
  import srm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  // raw pins
  input wire logic [srm_pkg::NUM_PINS-1:0] pin_raw,
  // filtered levels
  srm_pins_if.sync pins
);

  typedef struct packed {
    logic [NUM_PINS-1:0] s1;
    logic [NUM_PINS-1:0] s2;
    logic [NUM_PINS-1:0] s3;
    logic [NUM_PINS-1:0] filt;
  } srm_sync_s;

  srm_sync_s st;
  srm_sync_s next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pin_raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // s1 only feeds s2; the filter looks at s2 and s3
    for (int i = 0; i < NUM_PINS; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.filt[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{s1: PIN_RST, s2: PIN_RST, s3: PIN_RST, filt: PIN_RST};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign pins.sclk = st.filt[PIN_SCLK];
  assign pins.csb = st.filt[PIN_CSB];
  assign pins.sdio = st.filt[PIN_SDIO];

endmodule

`default_nettype wire

// [test/srm_reg_bank_props.sv]
`timescale 1ns/1ps
`default_nettype none

module srm_reg_bank_props
  import srm_pkg::*;
#(
  parameter int CH_COUNT = srm_pkg::NUM_CH
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  // serial pins
  input wire logic sclk,
  input wire logic csb,
  input wire logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  // active contents
  input wire logic lsb_first,
  input wire logic [7:0] modes_active,
  input wire logic [7:0] clock_active,
  input wire logic [CH_COUNT*8-1:0] test_io_active,
  input wire logic [CH_COUNT-1:0] channel_select,
  input wire logic commit_pending
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_commit_single: assert property (commit_pending |=> !commit_pending)
    else $error("commit flag held over one cycle");
  a_commit_on_rise: assert property ($rose(commit_pending) |-> sclk)
    else $error("commit outside a serial clock high phase");
  a_shadow_hold: assert property (($changed(clock_active) || $changed(modes_active)) |->
      $past(commit_pending) || (clock_active == RST_CLOCK && modes_active == RST_MODES))
    else $error("global active copy moved without commit");
  a_test_io_hold: assert property ($changed(test_io_active) |->
      $past(commit_pending) || test_io_active == '0)
    else $error("channel active copy moved without commit");
  a_reset_values: assert property ($rose(arst_n) |-> clock_active == RST_CLOCK &&
      modes_active == RST_MODES && !lsb_first && sdio_oe_n && test_io_active == '0 &&
      channel_select == {RST_CH_LOWER[5:4], RST_CH_UPPER, RST_CH_LOWER[3:0]})
    else $error("wrong value after reset");
  a_oe_needs_csb: assert property ($fell(sdio_oe_n) |-> !csb)
    else $error("pin driven outside a frame");
  a_oe_release: assert property (csb [*7] |-> sdio_oe_n)
    else $error("pin still driven after deselect");
  a_bit_on_low: assert property ($changed(sdio_out) && !sdio_oe_n && !$past(sdio_oe_n) |-> !sclk)
    else $error("read bit moved in clock high phase");
  a_order_on_rise: assert property ($changed(lsb_first) |-> sclk)
    else $error("shift order moved off a data byte");
  a_index_on_rise: assert property ($changed(channel_select) |-> sclk)
    else $error("index moved off a data byte");

  c_commit: cover property (commit_pending);
  c_read: cover property ($fell(sdio_oe_n));
  c_lsb: cover property ($rose(lsb_first));
  c_test_io: cover property ($changed(test_io_active));
endmodule

bind srm_reg_bank srm_reg_bank_props #(.CH_COUNT(CH_COUNT)) i_props (.clock, .arst_n, .ce, .sclk, .csb,
  .sdio_in, .sdio_out, .sdio_oe_n, .lsb_first, .modes_active, .clock_active, .test_io_active,
  .channel_select, .commit_pending);

`default_nettype wire

// [test/srm_spi_host.sv]
`timescale 1ns/1ps
`default_nettype none

module srm_spi_host (
  // clock
  input wire logic clock,
  // serial pins
  input wire logic sdio,
  output logic sclk,
  output logic csb,
  output logic sdio_drv
);
  logic lsb = 1'b0;
  // streaming length code instead of a byte count
  logic stream = 1'b0;
  initial begin
    sclk = 1'b0;
    csb = 1'b1;
    sdio_drv = 1'b0;
  end

  // 8 low and 9 high cycles: well above the synchroniser lag
  task automatic bit_io(input logic b, output logic r);
    @(posedge clock);
    sdio_drv <= b;
    sclk <= 1'b0;
    repeat (8) @(posedge clock);
    r = sdio;
    sclk <= 1'b1;
    repeat (8) @(posedge clock);
  endtask

  task automatic xfer(input logic rd, input int n, input logic [12:0] a, input logic [23:0] wd,
                      output logic [23:0] rdat);
    logic [15:0] ins;
    logic r;
    ins = {rd, stream ? 2'h3 : 2'(n - 1), a};
    rdat = '0;
    r = 1'b0;
    @(posedge clock);
    csb <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 16; i++) bit_io(ins[lsb ? i : 15 - i], r);
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 8; i++) begin
        // released line shows the inverse of its last level
        bit_io(rd ? ~r : wd[8*k + (lsb ? i : 7 - i)], r);
        rdat[8*k + (lsb ? i : 7 - i)] = r;
      end
    end
    @(posedge clock);
    sclk <= 1'b0;
    repeat (8) @(posedge clock);
    csb <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
endmodule

`default_nettype wire

// [test/srm_reg_bank_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module srm_reg_bank_tb;
  import srm_pkg::*;
  localparam logic [7:0] ID = 8'h5a; // arbitrary
  localparam logic [1:0] GRADE = 2'h2;
  logic clock = 1'b0, arst_n = 1'b0, ce = 1'b1;
  logic sclk, csb, sdio_drv, sdio_in, sdio_out, sdio_oe_n, lsb_first, commit_pending;
  logic [7:0] modes_active, clock_active, act8, act9;
  logic [79:0] test_io_active;
  logic [9:0] channel_select;
  logic [23:0] rd;
  logic [7:0] sh[256], tio[10], ta[10];
  logic [12:0] ra[8] = '{13'h0, 13'h1, 13'h2, 13'h3, 13'h4, 13'h5, 13'h9, 13'hff};
  logic [31:0] seed = 32'h57301e6b;
  int mismatches = 0, tests_run = 0, cyc = 0, commits = 0, ncommit = 0;

  assign sdio_in = sdio_oe_n ? sdio_drv : sdio_out;

  srm_reg_bank #(.PART_ID(ID), .SPEED_GRADE(GRADE)) i_dut (.clock(clock), .arst_n(arst_n), .ce(ce),
    .sclk(sclk), .csb(csb),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .lsb_first(lsb_first),
    .modes_active(modes_active), .clock_active(clock_active), .test_io_active(test_io_active),
    .channel_select(channel_select), .commit_pending(commit_pending));
  srm_spi_host i_host (.clock(clock), .sdio(sdio_in), .sclk(sclk), .csb(csb), .sdio_drv(sdio_drv));

  initial forever #5 clock = ~clock;

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [9:0] chs();
    return {sh[5][5:4], sh[4][3:0], sh[5][3:0]};
  endfunction

  function automatic void mreset();
    sh = '{default: 8'h00};
    sh[0] = 8'h18;
    sh[1] = ID;
    sh[2] = {2'h0, GRADE, 4'h0};
    sh[4] = 8'h0f;
    sh[5] = 8'h0f;
    sh[9] = 8'h01;
    tio = '{default: 8'h00};
    ta = '{default: 8'h00};
    act8 = 8'h00;
    act9 = 8'h01;
  endfunction

  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // model follows each byte in the order the device walks addresses
  task automatic wr(input logic [12:0] a, input int n, input logic [23:0] v);
    logic [12:0] ad;
    logic [7:0] b;
    i_host.xfer(1'b0, n, a, v, rd);
    for (int k = 0; k < n; k++) begin
      b = v[8*k +: 8];
      ad = i_host.lsb ? a + 13'(k) : a - 13'(k);
      if (ad == 13'h0 && (b & 8'h24) != 8'h00) mreset();
      else if (ad == 13'h0) sh[0] = 8'h18 | (b & 8'h42);
      else if (ad == 13'hff && b[0]) begin
        act8 = sh[8];
        act9 = sh[9];
        ta = tio;
        ncommit++;
      end else if (ad == 13'hd) begin
        for (int c = 0; c < 10; c++) if (chs() >> c & 10'h1) tio[c] = b;
      end else if (ad inside {13'h4, 13'h5, 13'h8, 13'h9}) sh[ad[7:0]] = b;
    end
    i_host.lsb = sh[0][6] | sh[0][1];
  endtask

  task automatic rdchk(input logic [12:0] a, input int n);
    logic [23:0] e;
    i_host.xfer(1'b1, n, a, 24'h0, rd);
    e = '0;
    for (int k = 0; k < n; k++) e[8*k +: 8] = sh[8'(i_host.lsb ? a + 13'(k) : a - 13'(k))];
    check("read", 80'(rd), 80'(e));
  endtask

  task automatic cmp_act();
    logic [79:0] t;
    for (int c = 0; c < 10; c++) t[8*c +: 8] = ta[c];
    check("test_io", test_io_active, t);
    check("chsel", 80'(channel_select), 80'(chs()));
    check("clock", 80'(clock_active), 80'(act9));
    check("modes", 80'(modes_active), 80'(act8));
    check("lsb", 80'(lsb_first), 80'(sh[0][6] | sh[0][1]));
    check("commits", 80'(commits), 80'(ncommit));
  endtask

  // whole run is about 20000 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    // counts high cycles, so a pulse longer than one cycle shows up too
    if (commit_pending === 1'b1) begin
      commits <= commits + 1;
    end
    if (cyc == 60000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    mreset();
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (6) @(posedge clock);
    cmp_act();
    foreach (ra[i]) rdchk(ra[i], 1);
    wr(13'h1, 1, 24'(rnd()));
    wr(13'h2, 1, 24'(rnd()));
    wr(13'h3, 1, 24'h0);
    rdchk(13'h3, 3);
    repeat (3) begin
      wr(13'h5, 2, {8'h00, rnd() & 8'h0f, rnd() & 8'h3f});
      cmp_act();
      wr(13'hd, 1, 24'(rnd()));
      wr(13'h9, 1, 24'(rnd()));
      wr(13'h8, 1, 24'(rnd() & 8'hf7));
      cmp_act();
      rdchk(13'h9, 1);
      wr(13'hff, 1, 24'h1);
      cmp_act();
      rdchk(13'hff, 1);
    end
    // frozen block must let a whole frame pass unseen
    ce <= 1'b0;
    i_host.xfer(1'b0, 1, 13'h5, 24'h0, rd);
    ce <= 1'b1;
    cmp_act();
    i_host.stream = 1'b1;
    wr(13'h9, 2, {8'h00, rnd() & 8'hf7, rnd()});
    rdchk(13'h9, 2);
    rdchk(13'h5, 3);
    i_host.stream = 1'b0;
    wr(13'h0, 1, 24'h42);
    cmp_act();
    rdchk(13'h0, 2);
    wr(13'h0, 1, 24'h66);
    cmp_act();
    rdchk(13'h0, 1);
    final_report();
  end
endmodule

`default_nettype wire
